// >>> led_dim_pkg.sv
/*
 Package for the six-channel LED driver control logic: timing counts,
 current codes, carrier structs and states.
 Assumes a 250 MHz clock and that the analog side reports comparators.
*/
package led_dim_pkg;
    localparam int CLK_MHZ = 250;
    // Off and shutdown timeout, microseconds
    localparam int OFF_TIMEOUT_US = 8000;
    localparam int OFF_TIMEOUT_CYC = OFF_TIMEOUT_US * CLK_MHZ;
    // Internal low-current PWM: 16 kHz period split in eighths
    localparam int INT_PWM_HZ = 16000;
    localparam int INT_PWM_CYC = (CLK_MHZ * 1000000) / INT_PWM_HZ;
    localparam int SLOT_CYC = INT_PWM_CYC / 8;
    // Pulse count that wraps back to full scale
    localparam logic [4:0] PULSE_WRAP = 5'h1F;
    localparam logic [4:0] PULSE_RESET = 5'h00;
    // Currents in units of 0.1 mA
    localparam logic [7:0] FULL_SCALE = 8'hF0;
    localparam logic [7:0] LOW_THRESHOLD = 8'h40;
    localparam logic [7:0] REF_HIGH = 8'h40;
    localparam logic [7:0] REF_MID = 8'h20;
    localparam logic [7:0] REF_LOW = 8'h10;
    localparam logic [7:0] REF_MIN = 8'h08;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_WAKE = 3'b100
    } power_state_e;

    // Per-regulator headroom comparator levels from the analog side
    typedef struct packed {
        logic [5:0] below_low;
        logic [5:0] above_high;
        logic supply_ok;
    } sense_s;

    // Commands to the analog current regulators
    typedef struct packed {
        logic [5:0] on;
        logic [5:0] neg_return;
        logic pump_run;
        logic [7:0] dc_group_a;
        logic [7:0] dc_pair;
        logic pair_pwm_gate;
        logic dim_gate;
        logic shutdown;
    } drive_s;
endpackage

// >>> level_table.sv
/*
 Brightness lookup: pulse count to DC level, reference and duty in eighths.
 Output is registered, one cycle after the count changes.
*/
module level_table (
    input wire logic clock,
    input wire logic [4:0] count,
    output logic [7:0] current,
    output logic [7:0] ref_level,
    output logic [3:0] eighths
);
    logic [7:0] cur;
    logic [7:0] rf;

    // Set current per pulse count, in 0.1 mA
    always_comb begin
        case (count)
            5'h00, 5'h1F: cur = led_dim_pkg::FULL_SCALE;
            5'h0C: cur = 8'h38;
            5'h0D: cur = 8'h30;
            5'h0E: cur = 8'h28;
            5'h0F: cur = 8'h20;
            5'h10: cur = 8'h1C;
            5'h11: cur = 8'h18;
            5'h12: cur = 8'h14;
            5'h13: cur = 8'h10;
            5'h14: cur = 8'h0E;
            5'h15: cur = 8'h0C;
            5'h16: cur = 8'h0A;
            default: begin
                if (count <= 5'h0B) begin
                    cur = 8'(8'hF0 - 8'(count) * 8'h10);
                end else begin
                    cur = 8'(5'h1F - count);
                end
            end
        endcase
        if (cur > led_dim_pkg::REF_MID) begin
            rf = led_dim_pkg::REF_HIGH;
        end else if (cur > led_dim_pkg::REF_LOW) begin
            rf = led_dim_pkg::REF_MID;
        end else if (cur > led_dim_pkg::REF_MIN) begin
            rf = led_dim_pkg::REF_LOW;
        end else begin
            rf = led_dim_pkg::REF_MIN;
        end
    end

    // Registered outputs; full scale keeps 8/8 duty
    always_ff @(posedge clock) begin
        if (cur >= led_dim_pkg::LOW_THRESHOLD) begin
            current <= cur;
            ref_level <= cur;
            eighths <= 4'h8;
        end else begin
            current <= cur;
            ref_level <= rf;
            // Widened so 5.6 mA times eight cannot wrap
            eighths <= 4'((12'(cur) * 12'h008) / 12'(rf));
        end
    end
endmodule // level_table

// >>> led_driver_dimming_control.sv
/*
 Digital control of a six-channel white LED driver: return-path switchover,
 pump control, enable/PWM input A, serial-pulse input B, internal PWM and
 timed shutdown. Assumes headroom comparators come from the analog side and
 both enable pins are asynchronous to the clock.
*/
// Operation
// - Regulator at low headroom threshold returns to negative rail
// - Regulator back at upper threshold returns to ground, with hysteresis
// - Pump idles while all active regulators have headroom, else runs
// - Each of six regulators switched independently
// - Pulse variant: A gates and dims group a, B gates and steps five/six
// - PWM variant: A gates group a and dims all six, B only gates
// - Above lockout, dimmed current follows duty on input A
// - Static input A acts as plain on/off
// - Rising B enables five and six at full scale
// - Each later B pulse lowers five/six current one step
// - Pulse past minimum wraps current to full scale
// - Counts one to eleven fall in 1.6mA steps; fresh enable full
// - Counts twelve to thirty follow the fine low-current steps
// - B low past timeout turns five and six off
// - Below threshold, reduced DC plus 16kHz PWM in eighths
// - Shutdown only after both inputs low for the timeout
// - Low-current reference chosen from four levels, duty is ratio
// - A low past timeout turns group a off
module led_driver_dimming_control #(
    parameter bit PULSE_VARIANT = 1'b1,
    parameter int OFF_CYCLES = led_dim_pkg::OFF_TIMEOUT_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable_dim_input_a,
    input wire logic enable_pulse_input_b,
    input wire led_dim_pkg::sense_s regulator_headroom,
    output led_dim_pkg::drive_s drive
);
    typedef led_dim_pkg::drive_s drive_s_t;
    typedef struct packed {
        logic [1:0] a_sync;
        logic [1:0] b_sync;
        logic b_prev;
        logic [22:0] a_low_cnt;
        logic [22:0] b_low_cnt;
        logic [22:0] both_low_cnt;
        logic a_on;
        logic b_on;
        logic [4:0] pulse_cnt;
        logic [5:0] neg_ret;
        led_dim_pkg::power_state_e pstate;
        logic [10:0] slot_cnt;
        logic [2:0] slot;
        drive_s_t drive;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [7:0] pair_current;
    logic [7:0] pair_ref;
    logic [3:0] pair_eighths;

    localparam logic [22:0] OFF_LIMIT = 23'(OFF_CYCLES);
    localparam logic [10:0] SLOT_LAST = 11'(led_dim_pkg::SLOT_CYC - 1);

    // Brightness lookup for regulators five and six
    level_table u_table (
        .clock(clock),
        .count(st_r.pulse_cnt),
        .current(pair_current),
        .ref_level(pair_ref),
        .eighths(pair_eighths)
    );

    // Saturating timeout counter: true once low for longer than the limit
    function automatic logic [22:0] low_count(input logic low,
                                              input logic [22:0] c);
        if (!low) begin
            low_count = 23'h0;
        end else if (c > OFF_LIMIT) begin
            low_count = c;
        end else begin
            low_count = 23'(c + 23'h1);
        end
    endfunction

    logic a_lvl;
    logic b_lvl;
    logic a_timeout;
    logic b_timeout;
    logic both_timeout;
    logic [5:0] active;
    assign a_lvl = st_r.a_sync[1];
    assign b_lvl = st_r.b_sync[1];
    assign a_timeout = st_r.a_low_cnt > OFF_LIMIT;
    assign b_timeout = st_r.b_low_cnt > OFF_LIMIT;
    assign both_timeout = st_r.both_low_cnt >= OFF_LIMIT;
    assign active = st_r.drive.on;

    // Next-state logic for the whole controller
    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers on both enable pins
        st_nxt.a_sync = {st_r.a_sync[0], enable_dim_input_a};
        st_nxt.b_sync = {st_r.b_sync[0], enable_pulse_input_b};
        st_nxt.b_prev = b_lvl;
        st_nxt.a_low_cnt = low_count(!a_lvl, st_r.a_low_cnt);
        st_nxt.b_low_cnt = low_count(!b_lvl, st_r.b_low_cnt);
        st_nxt.both_low_cnt = low_count(!a_lvl && !b_lvl,
                                        st_r.both_low_cnt);

        // Group a on while A high; short lows are PWM, not off
        if (a_lvl) begin
            st_nxt.a_on = 1'b1;
        end else if (a_timeout) begin
            st_nxt.a_on = 1'b0;
        end

        // B: enable, pulse counting and timeout off
        if (b_lvl && !st_r.b_prev) begin
            if (!st_r.b_on || b_timeout) begin // Long low: fresh enable
                st_nxt.b_on = 1'b1;
                st_nxt.pulse_cnt = led_dim_pkg::PULSE_RESET;
            end else if (PULSE_VARIANT) begin
                // Wrap after the minimum step back to full
                if (st_r.pulse_cnt == led_dim_pkg::PULSE_WRAP) begin
                    st_nxt.pulse_cnt = 5'h01;
                end else begin
                    st_nxt.pulse_cnt = 5'(st_r.pulse_cnt + 5'h01);
                end
            end
        end else if (b_timeout && st_r.b_on) begin
            st_nxt.b_on = 1'b0;
            st_nxt.pulse_cnt = led_dim_pkg::PULSE_RESET;
        end

        // Power state: shutdown only after the joint timeout
        case (st_r.pstate)
            led_dim_pkg::ST_ACTIVE: begin
                if (both_timeout && !a_lvl && !b_lvl) begin
                    st_nxt.pstate = led_dim_pkg::ST_SHUTDOWN;
                    st_nxt.a_on = 1'b0;
                    st_nxt.b_on = 1'b0;
                end
            end
            led_dim_pkg::ST_SHUTDOWN: begin
                if (a_lvl || b_lvl) begin
                    st_nxt.pstate = led_dim_pkg::ST_WAKE;
                    st_nxt.pulse_cnt = led_dim_pkg::PULSE_RESET;
                end
            end
            led_dim_pkg::ST_WAKE: st_nxt.pstate = led_dim_pkg::ST_ACTIVE;
            default: st_nxt.pstate = led_dim_pkg::ST_SHUTDOWN;
        endcase

        // Return-path switchover per regulator with hysteresis
        for (int i = 0; i < 6; i++) begin
            if (!active[i]) begin
                st_nxt.neg_ret[i] = 1'b0;
            end else if (regulator_headroom.below_low[i]) begin
                st_nxt.neg_ret[i] = 1'b1;
            end else if (regulator_headroom.above_high[i]) begin
                st_nxt.neg_ret[i] = 1'b0;
            end
        end

        // Internal 16 kHz PWM, eight slots per period
        if (st_r.slot_cnt == SLOT_LAST) begin
            st_nxt.slot_cnt = 11'h000;
            st_nxt.slot = 3'(st_r.slot + 3'h1);
        end else begin
            st_nxt.slot_cnt = 11'(st_r.slot_cnt + 11'h001);
        end

        // Drive outputs
        st_nxt.drive.shutdown = st_r.pstate == led_dim_pkg::ST_SHUTDOWN;
        st_nxt.drive.on = {st_r.b_on, st_r.b_on, {4{st_r.a_on}}};
        st_nxt.drive.neg_return = st_r.neg_ret;
        st_nxt.drive.pump_run = |st_r.neg_ret;
        st_nxt.drive.dc_group_a = led_dim_pkg::FULL_SCALE;
        // Pulse variant uses table; PWM variant holds full scale
        st_nxt.drive.dc_pair = PULSE_VARIANT ? pair_ref
                                             : led_dim_pkg::FULL_SCALE;
        st_nxt.drive.pair_pwm_gate = PULSE_VARIANT ?
            ({1'b0, st_r.slot} < pair_eighths) : 1'b1;
        // Duty on A gates current only above supply lockout
        st_nxt.drive.dim_gate = a_lvl && regulator_headroom.supply_ok;
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.pstate <= led_dim_pkg::ST_SHUTDOWN;
            st_r.drive.shutdown <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Group-a PWM always via A; pair dimmed by A only in PWM variant
    assign drive = st_r.drive;
endmodule // led_driver_dimming_control

// >>> led_dim_chk.sv
/* Checker for the LED control block ports.
 Assumes OFF_CYCLES is the off timeout in clock cycles. */
module led_dim_chk #(
    parameter int OFF_CYCLES = 50
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable_dim_input_a,
    input wire logic enable_pulse_input_b,
    input wire led_dim_pkg::sense_s regulator_headroom,
    input wire led_dim_pkg::drive_s drive
);
    int low_a_r;
    int low_b_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Pin low times, saturating so they never wrap
    always_ff @(posedge clock) begin
        low_a_r <= enable_dim_input_a ? 0 :
            (low_a_r > OFF_CYCLES ? low_a_r : low_a_r + 1);
        low_b_r <= enable_pulse_input_b ? 0 :
            (low_b_r > OFF_CYCLES ? low_b_r : low_b_r + 1);
    end
    chk_reset_shut: assert property ($rose(rst_n) |->
        drive.shutdown && drive.on == 6'h00) else $error("reset state");
    chk_shut_time: assert property ($rose(drive.shutdown) |->
        low_a_r >= OFF_CYCLES && low_b_r >= OFF_CYCLES)
        else $error("early shutdown");
    chk_pair_off: assert property ($fell(drive.on[4]) |->
        low_b_r > OFF_CYCLES) else $error("pair off early");
    chk_group_off: assert property ($fell(drive.on[0]) |->
        low_a_r > OFF_CYCLES) else $error("group off early");
    chk_pair_on: assert property ($rose(enable_pulse_input_b) |->
        ##[2:8] drive.on[5:4] == 2'b11) else $error("pair not on");
    chk_group_on: assert property ($rose(enable_dim_input_a) |->
        ##[2:8] drive.on[3:0] == 4'hF) else $error("group not on");
    chk_neg_switch: assert property ($rose(regulator_headroom.below_low[0])
        && drive.on[0] |-> ##[1:4] drive.neg_return[0])
        else $error("no switch to rail");
    chk_neg_back: assert property ($rose(regulator_headroom.above_high[0])
        |-> ##[1:4] !drive.neg_return[0])
        else $error("no switch to ground");
    chk_pump_idle: assert property ((drive.neg_return == 6'h00) [*3] |->
        !drive.pump_run) else $error("pump runs idle");
    chk_pump_run: assert property ((|drive.neg_return) [*3] |->
        drive.pump_run) else $error("pump stopped");
    chk_dim_supply: assert property ((!regulator_headroom.supply_ok) [*3]
        |-> !drive.dim_gate) else $error("dim in lockout");
endmodule // led_dim_chk

bind led_driver_dimming_control led_dim_chk #(
    .OFF_CYCLES(OFF_CYCLES)
) led_dim_chk_inst (
    .clock(clock),
    .rst_n(rst_n),
    .enable_dim_input_a(enable_dim_input_a),
    .enable_pulse_input_b(enable_pulse_input_b),
    .regulator_headroom(regulator_headroom),
    .drive(drive)
);

// >>> host_pins.sv
/* Host model driving the two enable pins.
 Assumes its tasks are called from one process. */
module host_pins (
    input wire logic clock,
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both pins start low, device in shutdown
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // Static levels: plain on/off use
    task automatic set_pins(input logic a, input logic b);
        @(posedge clock);
        pin_a <= a;
        pin_b <= b;
    endtask
    // Short low pulse, far under the off timeout
    task automatic pulse_b();
        @(posedge clock);
        pin_b <= 1'b0;
        repeat (4) @(posedge clock);
        pin_b <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    // 25% duty; band scaled with the short timeout
    task automatic pwm_a(input int reps);
        repeat (reps) begin
            @(posedge clock);
            pin_a <= 1'b1;
            repeat (10) @(posedge clock);
            pin_a <= 1'b0;
            repeat (29) @(posedge clock);
        end
    endtask
endmodule // host_pins

// >>> tb_top.sv
/* Self-checking bench for the LED control block.
 Assumes the host model and checker are compiled before. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OFF = 50;
    localparam int SLOT = led_dim_pkg::SLOT_CYC;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic pin_a;
    logic pin_b;
    led_dim_pkg::sense_s sense = '{6'h00, 6'h3F, 1'b1};
    led_dim_pkg::drive_s drive;
    led_dim_pkg::drive_s drive_pwm;
    int num_errors = 0;
    int check_count = 0;
    int cnt;
    led_driver_dimming_control #(.PULSE_VARIANT(1'b1), .OFF_CYCLES(OFF))
        led_driver_dimming_control_inst (.clock(clock), .rst_n(rst_n),
        .enable_dim_input_a(pin_a), .enable_pulse_input_b(pin_b),
        .regulator_headroom(sense), .drive(drive));
    // PWM-only variant on the same pins: B must only gate five and six
    if (1'b1) begin : pwm_variant
        led_driver_dimming_control #(.PULSE_VARIANT(1'b0), .OFF_CYCLES(OFF))
            led_driver_dimming_control_inst (.clock(clock), .rst_n(rst_n),
            .enable_dim_input_a(pin_a), .enable_pulse_input_b(pin_b),
            .regulator_headroom(sense), .drive(drive_pwm));
    end
    host_pins host_pins_inst (.clock(clock), .pin_a(pin_a), .pin_b(pin_b));
    // 4 ns clock
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            num_errors++;
            $display("wrong value at %0t: got %0d want %0d", $time, got, exp);
        end
    endtask
    // Expected DC level for a pulse count, 0.1 mA units
    function automatic logic [7:0] exp_dc(input int n);
        if (n == 0) return 8'hF0;
        if (n < 12) return 8'(240 - 16 * n);
        if (n < 15) return 8'h40;
        if (n < 19) return 8'h20;
        return (n < 23) ? 8'h10 : 8'h08;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic t_switch();
        host_pins_inst.set_pins(1'b1, 1'b1);
        wt(10);
        check_val({2'b00, drive.on}, 8'h3F);
        check_val(drive.dc_pair, 8'hF0);
        check_val(drive.dc_group_a, 8'hF0);
        @(posedge clock) sense <= '{6'h01, 6'h3E, 1'b1};
        wt(6);
        check_val({1'b0, drive.pump_run, drive.neg_return}, 8'h41);
        @(posedge clock) sense <= '{6'h00, 6'h3E, 1'b1};
        wt(6);
        check_val({2'b00, drive.neg_return}, 8'h01);
        @(posedge clock) sense <= '{6'h00, 6'h3F, 1'b1};
        wt(6);
        check_val({1'b0, drive.pump_run, drive.neg_return}, 8'h00);
        $display("test switch ended");
    endtask
    task automatic t_steps();
        for (int n = 1; n <= 32; n++) begin
            host_pins_inst.pulse_b();
            #1;
            check_val(drive.dc_pair, exp_dc(n % 31));
            if (n == 12 || n == 30) begin
                cnt = 0;
                repeat (8 * led_dim_pkg::SLOT_CYC) @(negedge clock)
                    cnt += drive.pair_pwm_gate;
                // One full period: 7/8 at 5.6 mA, 1/8 at 0.1 mA
                check_cnt(cnt, (n == 12 ? 7 : 1) * SLOT);
            end
        end
        check_val({6'h00, drive.on[5:4]}, 8'h03);
        check_val(drive_pwm.dc_pair, 8'hF0);
        check_val({7'h00, drive_pwm.pair_pwm_gate}, 8'h01);
        $display("test steps ended");
    endtask
    task automatic t_dim();
        cnt = 0;
        fork
            host_pins_inst.pwm_a(5);
            begin
                wt(40);
                repeat (160) @(negedge clock) cnt += drive.dim_gate;
            end
        join
        check_cnt(cnt, 40);
        host_pins_inst.set_pins(1'b1, 1'b1);
        @(posedge clock) sense <= '{6'h00, 6'h3F, 1'b0};
        wt(6);
        check_val({7'h00, drive.dim_gate}, 8'h00);
        @(posedge clock) sense <= '{6'h00, 6'h3F, 1'b1};
        $display("test dim ended");
    endtask
    task automatic t_off();
        host_pins_inst.set_pins(1'b1, 1'b0);
        wt(OFF + 10);
        check_val({2'b00, drive.on}, 8'h0F);
        check_val(drive.dc_pair, 8'hF0);
        host_pins_inst.set_pins(1'b0, 1'b1);
        wt(OFF + 10);
        check_val({2'b00, drive.on}, 8'h30);
        check_val(drive.dc_pair, 8'hF0);
        host_pins_inst.set_pins(1'b0, 1'b0);
        wt(OFF - 20);
        check_val({7'h00, drive.shutdown}, 8'h00);
        wt(30);
        check_val({7'h00, drive.shutdown}, 8'h01);
        $display("test off ended");
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        final_report();
    end
    // Reset, then the scenarios in order
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        wt(1);
        check_val({1'b0, drive.shutdown, drive.on}, 8'h40);
        t_switch();
        t_steps();
        t_dim();
        t_off();
        final_report();
    end
endmodule // tb_top
